/* verilog/spio_ports.sv */
// Purpose: seven shared 8-bit general-purpose i/o ports
// Assumes: peripheral enables and outputs arrive on core_clk
// Notes: register access is by plain select/strobe ports
`timescale 1ns/1ps
`include "spio_defs.svh"
module spio_ports (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic clkEn,
  input wire spio_pkg::spio_port_t portSel,
  input wire logic dataWr,
  input wire logic dirWr,
  input wire logic pullWr,
  input wire logic slewWr,
  input wire spio_pkg::spio_byte_t wrData,
  output spio_pkg::spio_byte_t rdData,
  input wire logic [55:0] pinIn,
  output logic [55:0] pinOut,
  output logic [55:0] pinOe,
  output logic [55:0] pullEn,
  output logic [55:0] slewEn,
  output logic [55:0] pinSync,
  input wire spio_pkg::spio_byte_t keypadEn,
  input wire logic convEn,
  input wire spio_pkg::spio_byte_t convPinEn,
  input wire logic serial2En,
  input wire logic serial2Tx,
  input wire logic twoWireEn,
  input wire logic twoWireSdaOe,
  input wire logic twoWireSclOe,
  input wire logic [7:0] timerOwn,
  input wire logic [7:0] timerOe,
  input wire logic [7:0] timerOut,
  input wire logic serial1En,
  input wire logic serial1Tx,
  input wire logic spiEn,
  input wire logic [3:0] spiOe,
  input wire logic [3:0] spiOut,
  input wire logic backgroundPinEnable,
  input wire logic bkgOe,
  input wire logic bkgOut,
  input wire logic oscEn,
  output logic modeSelect,
  output logic bkgPinActive
);
  spio_pkg::spio_byte_t own [`SPIO_NPORT];
  spio_pkg::spio_byte_t oe [`SPIO_NPORT];
  spio_pkg::spio_byte_t out [`SPIO_NPORT];
  spio_pkg::spio_byte_t pf [`SPIO_NPORT];
  spio_pkg::spio_byte_t ro [`SPIO_NPORT];
  spio_pkg::spio_byte_t rd [`SPIO_NPORT];
  logic inReset_q;
  logic modeSel_q;
  logic bkgOn;

  // ------------------------------------------------------------
  // enable-gated pin masks
  // ------------------------------------------------------------
  function automatic spio_pkg::spio_byte_t maskIf(
    input logic en,
    input spio_pkg::spio_byte_t m
  );
    maskIf = en ? m : `SPIO_RST_BYTE;
  endfunction

  // ------------------------------------------------------------
  // reset-time mode select sampling
  // ------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      inReset_q <= 1'b1;
    end else if (clkEn) begin
      inReset_q <= 1'b0;
    end
  end

  // capture the synchronised g0 level on the first cycle after reset
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      modeSel_q <= 1'b0;
    end else if (clkEn && inReset_q) begin
      modeSel_q <= pinSync[`SPIO_PG*8];
    end
  end

  assign modeSelect = modeSel_q;
  // background owns g0 only after reset leaves
  assign bkgOn = backgroundPinEnable && !inReset_q;
  assign bkgPinActive = bkgOn;

  // ------------------------------------------------------------
  // peripheral override decode
  // ------------------------------------------------------------
  always_comb begin
    for (int p = 0; p < `SPIO_NPORT; p++) begin
      own[p] = `SPIO_RST_BYTE;
      oe[p] = `SPIO_RST_BYTE;
      out[p] = `SPIO_RST_BYTE;
      pf[p] = `SPIO_RST_BYTE;
      ro[p] = `SPIO_RST_BYTE;
    end
    // forced inputs: owned with driver off
    own[`SPIO_PA] = keypadEn;
    own[`SPIO_PB] = convEn ? convPinEn : `SPIO_RST_BYTE;
    // port c: serial2 tx/rx and two-wire open-drain pins
    own[`SPIO_PC] = maskIf(serial2En, `SPIO_PC_SCI_MASK)
                  | maskIf(twoWireEn, `SPIO_PC_TWB_MASK);
    oe[`SPIO_PC][0] = serial2En;
    out[`SPIO_PC][0] = serial2Tx;
    oe[`SPIO_PC][2] = twoWireEn & twoWireSdaOe;
    oe[`SPIO_PC][3] = twoWireEn & twoWireSclOe;
    // port d: timerOwn owns any of the eight pins, as the t1 and t2 masks together cover all of them
    own[`SPIO_PD] = timerOwn
                  & (`SPIO_PD_T2_MASK | `SPIO_PD_T1_MASK);
    oe[`SPIO_PD] = timerOwn & timerOe;
    out[`SPIO_PD] = timerOut;
    // port e: serial1 then spi
    own[`SPIO_PE] = maskIf(serial1En, `SPIO_PE_SCI_MASK)
                  | maskIf(spiEn, `SPIO_PE_SPI_MASK);
    oe[`SPIO_PE][0] = serial1En;
    out[`SPIO_PE][0] = serial1Tx;
    oe[`SPIO_PE][5:2] = spiEn ? spiOe : 4'h0;
    out[`SPIO_PE][5:2] = spiOut;
    // port g: background on g0, oscillator on g2..g1
    own[`SPIO_PG] = maskIf(bkgOn, `SPIO_PG_BKG_MASK)
                  | maskIf(oscEn, `SPIO_PG_OSC_MASK);
    oe[`SPIO_PG][0] = bkgOn & bkgOe;
    out[`SPIO_PG][0] = bkgOut;
    // pullup also held through reset so the mode pin idles high
    pf[`SPIO_PG][0] = backgroundPinEnable;
    ro[`SPIO_PG][0] = 1'b1;
  end

  // ------------------------------------------------------------
  // port instances
  // ------------------------------------------------------------
  for (genvar p = 0; p < `SPIO_NPORT; p++) begin : gPort
    spio_pin_cell uCell (
      .core_clk(core_clk),
      .nrst(nrst),
      .clkEn(clkEn),
      .dataWr(dataWr && portSel == 3'(p)),
      .dirWr(dirWr && portSel == 3'(p)),
      .pullWr(pullWr && portSel == 3'(p)),
      .slewWr(slewWr && portSel == 3'(p)),
      .wrData(wrData),
      .pinIn(pinIn[p*8 +: 8]),
      .perOwn(own[p]),
      .perOe(oe[p]),
      .perOut(out[p]),
      .pullForce(pf[p]),
      .readOwnOut(ro[p]),
      .rdData(rd[p]),
      .pinOut(pinOut[p*8 +: 8]),
      .pinOe(pinOe[p*8 +: 8]),
      .pullEn(pullEn[p*8 +: 8]),
      .slewEn(slewEn[p*8 +: 8]),
      .pinSync(pinSync[p*8 +: 8])
    );
  end

  // ------------------------------------------------------------
  // read mux
  // ------------------------------------------------------------
  // unmapped port select reads as zero
  always_comb begin
    rdData = `SPIO_RST_BYTE;
    for (int p = 0; p < `SPIO_NPORT; p++) begin
      if (portSel == 3'(p)) begin
        rdData = rd[p];
      end
    end
  end
endmodule

/* verilog/spio_defs.svh */
// Purpose: constants for the shared parallel i/o ports
// Assumes: seven 8-bit ports, index 0..6 = a..g
// Notes: definitions only
`ifndef SPIO_DEFS_SVH
`define SPIO_DEFS_SVH
`define SPIO_NPORT 7
`define SPIO_PW 8
`define SPIO_PA 0
`define SPIO_PB 1
`define SPIO_PC 2
`define SPIO_PD 3
`define SPIO_PE 4
`define SPIO_PF 5
`define SPIO_PG 6
`define SPIO_RST_BYTE 8'h00
`define SPIO_PD_T2_MASK 8'hf8
`define SPIO_PD_T1_MASK 8'h07
`define SPIO_PE_SCI_MASK 8'h03
`define SPIO_PE_SPI_MASK 8'h3c
`define SPIO_PC_SCI_MASK 8'h03
`define SPIO_PC_TWB_MASK 8'h0c
`define SPIO_PG_OSC_MASK 8'h06
`define SPIO_PG_BKG_MASK 8'h01
`endif

/* verilog/spio_pkg.sv */
// Purpose: types for the shared parallel i/o ports
// Assumes: spio_defs.svh gives the widths
// Notes: port selector is a plain 3-bit logic type
`include "spio_defs.svh"
package spio_pkg;
  typedef logic [`SPIO_PW-1:0] spio_byte_t;
  typedef logic [2:0] spio_port_t;
endpackage

/* verilog/spio_pin_cell.sv */
// Purpose: one 8-bit port: latch, direction, pullup, slew, pin mux
// Assumes: peripheral override masks come in already decoded
// Notes: pin inputs are synchronised by two flops before any read
`timescale 1ns/1ps
`include "spio_defs.svh"
module spio_pin_cell (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic clkEn,
  input wire logic dataWr,
  input wire logic dirWr,
  input wire logic pullWr,
  input wire logic slewWr,
  input wire spio_pkg::spio_byte_t wrData,
  input wire spio_pkg::spio_byte_t pinIn,
  input wire spio_pkg::spio_byte_t perOwn,
  input wire spio_pkg::spio_byte_t perOe,
  input wire spio_pkg::spio_byte_t perOut,
  input wire spio_pkg::spio_byte_t pullForce,
  input wire spio_pkg::spio_byte_t readOwnOut,
  output spio_pkg::spio_byte_t rdData,
  output spio_pkg::spio_byte_t pinOut,
  output spio_pkg::spio_byte_t pinOe,
  output spio_pkg::spio_byte_t pullEn,
  output spio_pkg::spio_byte_t slewEn,
  output spio_pkg::spio_byte_t pinSync
);
  spio_pkg::spio_byte_t latch_q;
  spio_pkg::spio_byte_t dir_q;
  spio_pkg::spio_byte_t pull_q;
  spio_pkg::spio_byte_t slew_q;
  spio_pkg::spio_byte_t meta_q;
  spio_pkg::spio_byte_t sync_q;
  spio_pkg::spio_byte_t pinOut_q;
  spio_pkg::spio_byte_t pinOe_q;
  spio_pkg::spio_byte_t outD;
  spio_pkg::spio_byte_t oeD;

  // -----------------------------------------------------------
  // control registers
  // -----------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      latch_q <= `SPIO_RST_BYTE;
    end else if (clkEn && dataWr) begin
      latch_q <= wrData;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      dir_q <= `SPIO_RST_BYTE;
      pull_q <= `SPIO_RST_BYTE;
      slew_q <= `SPIO_RST_BYTE;
    end else if (clkEn) begin
      if (dirWr) begin
        dir_q <= wrData;
      end
      if (pullWr) begin
        pull_q <= wrData;
      end
      if (slewWr) begin
        slew_q <= wrData;
      end
    end
  end

  // -----------------------------------------------------------
  // pin synchroniser
  // -----------------------------------------------------------
  // no reset here: the mode pin level must be seen while reset is held
  always_ff @(posedge core_clk) begin
    if (clkEn) begin
      meta_q <= pinIn;
      sync_q <= meta_q;
    end
  end

  // -----------------------------------------------------------
  // pin drive
  // -----------------------------------------------------------
  always_comb begin
    // peripheral wins over latch where it owns the pin
    outD = (perOwn & perOut) | (~perOwn & latch_q);
    oeD = (perOwn & perOe) | (~perOwn & dir_q);
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      pinOut_q <= `SPIO_RST_BYTE;
      pinOe_q <= `SPIO_RST_BYTE;
    end else if (clkEn) begin
      pinOut_q <= outD;
      pinOe_q <= oeD;
    end
  end

  assign pinOut = pinOut_q;
  assign pinOe = pinOe_q;
  // pullup only while the pin is not driven, unless forced on
  assign pullEn = (pull_q & ~pinOe_q) | pullForce;
  assign slewEn = slew_q & pinOe_q;
  assign pinSync = sync_q;
  // direction bit picks read source even under peripheral control
  assign rdData = (dir_q & ~readOwnOut & latch_q)
                | (dir_q & readOwnOut & pinOut_q)
                | (~dir_q & sync_q);
endmodule

/* testbench/spio_ports_properties.sv */
// Purpose: port-level properties of spio_ports
// Assumes: one clock domain, attached by bind
// Notes: owned pins are judged one registered stage late
`timescale 1ns/1ps
module spio_ports_chk (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic clkEn,
  input wire spio_pkg::spio_port_t portSel,
  input wire logic dirWr,
  input wire spio_pkg::spio_byte_t wrData,
  input wire logic [55:0] pinOut,
  input wire logic [55:0] pinOe,
  input wire logic [55:0] pullEn,
  input wire spio_pkg::spio_byte_t keypadEn,
  input wire logic convEn,
  input wire spio_pkg::spio_byte_t convPinEn,
  input wire logic twoWireEn,
  input wire logic twoWireSdaOe,
  input wire logic [7:0] timerOwn,
  input wire logic [7:0] timerOe,
  input wire logic [7:0] timerOut,
  input wire logic serial1En,
  input wire logic serial1Tx,
  input wire logic backgroundPinEnable
);
  // ----
  // properties
  // ----
  default clocking dc @(posedge core_clk); endclocking
  default disable iff (!nrst);
  sequence s_run;
    nrst && clkEn;
  endsequence
  sequence s_f_dir;
    s_run ##0 dirWr && portSel == 3'h5 && wrData == 8'h0f ##1 s_run ##0 !dirWr;
  endsequence
  chk_reset_idle: assert property (
    disable iff (1'b0) !nrst |=> pinOe == 56'h0)
    else $error("pin driven after reset");
  chk_keypad_input: assert property (
    s_run |=> (pinOe[7:0] & $past(keypadEn)) == 8'h00)
    else $error("keypad pin driven");
  chk_conv_input: assert property (
    s_run ##0 convEn |=> (pinOe[15:8] & $past(convPinEn)) == 8'h00)
    else $error("converter pin driven");
  chk_serial_one_pins: assert property (
    s_run ##0 serial1En |=> pinOe[32] && !pinOe[33]
      && pinOut[32] == $past(serial1Tx))
    else $error("serial1 pins wrong");
  chk_two_wire_data: assert property (
    s_run ##0 twoWireEn |=> !pinOut[18] && pinOe[18] == $past(twoWireSdaOe))
    else $error("two-wire data pin wrong");
  chk_timer_drive: assert property (
    s_run |=> ((pinOut[31:24] ^ $past(timerOut)) & $past(timerOwn)
      & $past(timerOe)) == 8'h00)
    else $error("timer value not driven");
  chk_bkg_pullup: assert property (
    (nrst && clkEn && backgroundPinEnable) [*3] |-> pullEn[48])
    else $error("g0 pullup off");
  chk_dir_drives: assert property (
    s_f_dir |=> pinOe[47:40] == 8'h0f)
    else $error("direction did not enable drivers");
endmodule
bind spio_ports spio_ports_chk u_chk (.*);

/* testbench/spio_board.sv */
// Purpose: board side of the 56 port pins
// Assumes: bench forces pins through drv and drvEn
// Notes: a pin nobody drives and without pullup toggles
`timescale 1ns/1ps
module spio_board (
  input wire logic core_clk,
  input wire logic [55:0] pinOut,
  input wire logic [55:0] pinOe,
  input wire logic [55:0] pullEn,
  input wire logic [55:0] drv,
  input wire logic [55:0] drvEn,
  output logic [55:0] pinIn
);
  // a floating pin must never read as a steady level
  logic [55:0] floatQ = 56'h0;
  always_ff @(posedge core_clk) begin
    floatQ <= ~floatQ;
  end
  assign pinIn = (pinOe & pinOut) | (~pinOe & drvEn & drv)
    | (~pinOe & ~drvEn & (pullEn | floatQ));
endmodule

/* testbench/tb_top.sv */
// Purpose: self-checking bench for spio_ports
// Assumes: 100 MHz core_clk, board model on the pins
// Notes: run is about 76 cycles
`timescale 1ns/1ps
module tb_top;
  logic core_clk = 1'b0;
  logic nrst, clkEn, dataWr, dirWr, pullWr, slewWr;
  spio_pkg::spio_port_t portSel;
  spio_pkg::spio_byte_t wrData, rdData, keypadEn, convPinEn;
  logic [7:0] timerOwn, timerOe, timerOut;
  logic [3:0] spiOe, spiOut;
  logic convEn, serial2En, serial2Tx, twoWireEn, twoWireSdaOe;
  logic twoWireSclOe, serial1En, serial1Tx, spiEn, bkgOe, bkgOut;
  logic oscEn, backgroundPinEnable, modeSelect, bkgPinActive;
  logic [55:0] pinIn, pinOut, pinOe, pullEn, slewEn, pinSync, drv, drvEn;
  int n_errors = 0;
  int checks = 0;
  // ----
  // harness
  // ----
  always #5 core_clk = ~core_clk;
  spio_ports dut (.*);
  spio_board board (.*);
  task automatic cmp(input logic [55:0] got, input logic [55:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic wr(input spio_pkg::spio_port_t p, input logic [3:0] k,
                    input spio_pkg::spio_byte_t d);
    @(posedge core_clk);
    portSel <= p;
    wrData <= d;
    {slewWr, pullWr, dirWr, dataWr} <= k;
    @(posedge core_clk);
    {slewWr, pullWr, dirWr, dataWr} <= 4'h0;
  endtask
  task automatic rd(input spio_pkg::spio_port_t p, input logic [7:0] e);
    @(posedge core_clk);
    portSel <= p;
    #1;
    cmp(rdData, e);
  endtask
  task automatic done(input string s);
    $display("test %s ended, checks=%0d", s, checks);
  endtask
  task automatic print_verdict();
    $display("checks=%0d n_errors=%0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // tests need about 0.8 us; 25 times that means a hang
  initial begin
    #20000;
    n_errors++;
    print_verdict();
  end
  initial begin
    {nrst, dataWr, dirWr, pullWr, slewWr, convEn, serial2En, serial2Tx,
     twoWireEn, twoWireSdaOe, twoWireSclOe, serial1En, serial1Tx, spiEn,
     bkgOe, bkgOut, oscEn, portSel, wrData, keypadEn, convPinEn} = '0;
    {timerOwn, timerOe, timerOut, spiOe, spiOut} = '0;
    {clkEn, backgroundPinEnable} = 2'h3;
    drv = {8'h00, 8'h3c, 32'h0, 8'h41};
    drvEn = {8'h00, 8'hff, 32'h0, 8'hff};
    repeat (20) @(posedge core_clk);
    nrst <= 1'b1;
    tick(2);
    cmp(pinOe, 56'h0);
    cmp(pullEn, {8'h01, 48'h0});
    cmp({modeSelect, bkgPinActive}, 2'h3);
    done("reset");
    wr(3'h5, 4'h1, 8'ha5);
    wr(3'h5, 4'h2, 8'h0f);
    wr(3'h5, 4'h4, 8'hf0);
    wr(3'h5, 4'h8, 8'hff);
    tick(3);
    cmp(pinOut[43:40], 4'h5);
    cmp({pullEn[47:40], slewEn[47:40]}, 16'hf00f);
    cmp(pinSync[47:40], 8'h35);
    rd(3'h5, 8'h35);
    done("gpio");
    @(posedge core_clk);
    keypadEn <= 8'hff;
    {convEn, convPinEn} <= 9'h10f;
    wr(3'h0, 4'h3, 8'h96);
    wr(3'h1, 4'h3, 8'hff);
    tick(2);
    cmp(pinOe[15:0], 16'hf000);
    rd(3'h0, 8'hd7);
    @(posedge core_clk);
    {keypadEn, convEn} <= 9'h0;
    tick(2);
    cmp({pinOe[15:0], pinOut[15:0]}, 32'hff96ff96);
    done("override");
    @(posedge core_clk);
    {serial2En, serial2Tx, twoWireEn, twoWireSdaOe, twoWireSclOe} <= 5'h1f;
    {timerOwn, timerOe, timerOut} <= 24'hfff0a5;
    {serial1En, serial1Tx, spiEn, spiOe, spiOut} <= 11'h5af;
    {bkgOe, bkgOut, oscEn} <= 3'h7;
    tick(2);
    cmp(pinOe[55:16], {8'h01, 8'h0f, 8'h29, 8'hf0, 8'h0d});
    cmp(pinOut[55:16] & pinOe[55:16], 40'h010528a001);
    cmp(pullEn[48], 1'b1);
    wr(3'h6, 4'h2, 8'hff);
    wr(3'h6, 4'h1, 8'h00);
    tick(2);
    cmp(pinOe[55:48], 8'hf9);
    rd(3'h6, 8'h01);
    @(posedge core_clk);
    backgroundPinEnable <= 1'b0;
    tick(2);
    rd(3'h6, 8'h00);
    cmp(bkgPinActive, 1'b0);
    done("peripherals");
    @(posedge core_clk);
    clkEn <= 1'b0;
    wr(3'h5, 4'h3, 8'hff);
    clkEn <= 1'b1;
    wr(3'h7, 4'hf, 8'hff);
    tick(2);
    cmp(pinOut[47:40] & pinOe[47:40], 8'h05);
    rd(3'h7, 8'h00);
    done("refused");
    @(posedge core_clk);
    drvEn[48] <= 1'b1;
    nrst <= 1'b0;
    tick(3);
    cmp({pinOe, pullEn}, 112'h0);
    @(posedge core_clk);
    nrst <= 1'b1;
    tick(3);
    rd(3'h5, 8'h3c);
    cmp(modeSelect, 1'b0);
    done("rereset");
    print_verdict();
  end
endmodule
